// ### rtl/osd_framer_defs.svh
// Constants of the serial command framer
`ifndef OSD_FRAMER_DEFS_SVH
`define OSD_FRAMER_DEFS_SVH
`define END_CODE        8'hff
`define DISPLAY_OFF     8'hfe
`define LAST_COLUMN     5'h1b
`define LAST_ROW        4'hb
`define COL_RESET       5'h00
`define ROW_RESET       4'h0
`define BIT_CNT_RESET   3'h7
`define WRITE_TAG       2'h3
`define WRITE_TAG_MSB   7
`define WRITE_TAG_LSB   6
`endif

// ### rtl/osd_framer_pkg.sv
// Types of the serial command framer
package osd_framer_pkg;
  typedef enum logic [1:0] {
    ST_FIRST  = 2'b00,
    ST_SECOND = 2'b01,
    ST_RUN    = 2'b10
  } frame_state_e;
endpackage

// ### rtl/osd_link_sync.sv
// Two-stage synchroniser for the serial link pins
`timescale 1ns/100ps
module osd_link_sync (
  // Clock and reset
  input  wire logic clk_sys,
  input  wire logic rst_b,
  // Raw pin level
  input  wire logic pin_in,
  // Synchronised level
  output logic      pin_sync
);
  logic meta_q;

  // Two flip-flops, second one read only
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      meta_q   <= 1'b0;
      pin_sync <= 1'b0;
    end else begin
      meta_q   <= pin_in;
      pin_sync <= meta_q;
    end
  end
endmodule

// ### rtl/osd_serial_command_framer.sv
// Serial command framer of the on-screen display controller
// Summary of operation
// - In a run, each further byte is a character code with kept attributes.
// - Run ends on chip select high or on end code FFH.
// - Successive writes stay in the bank chosen by the first byte.
// - Codes FEH and FFH hold no pattern; FFH ends the run.
// - Blank cell shows picture without background, else background colour.
// - Display-off cell always passes picture, never background.
// - Bits shift in MSB first from D15 or LSB first from D8.
// - Column increments per write, wrapping 27 to next row, row 11 to 0.
// - Characters are stored only while the dot oscillator runs.
`timescale 1ns/100ps
`include "osd_framer_defs.svh"
module osd_serial_command_framer (
  // Clock and reset
  input  wire logic        clk_sys,
  input  wire logic        rst_b,
  // Serial link pins
  input  wire logic        cs_b,
  input  wire logic        sclk,
  input  wire logic        sdata,
  // Configuration
  input  wire logic        lsb_first,
  input  wire logic        internal_dot_oscillator,
  input  wire logic        bg_enable,
  // Command output
  output logic [15:0]      cmd_word_q,
  output logic             cmd_valid_q,
  output logic             cmd_two_byte_q,
  // Video RAM write port
  output logic             vram_we_q,
  output logic [8:0]       vram_char_q,
  output logic [3:0]       vram_row_q,
  output logic [4:0]       vram_col_q,
  output logic [5:0]       vram_attr_q,
  // Cell classification for display path
  output logic             cell_pass_picture_q,
  output logic             cell_show_bg_q,
  // Status
  output logic             run_active_q
);
  // Cell rendering: blank or display-off code, background enable
  function automatic logic [1:0] cell_view(input logic [7:0] code, input logic bg);
    logic off;
    off = (code == `DISPLAY_OFF);
    // Bit 1 pass picture, bit 0 show background
    cell_view = {off | ~bg, ~off & bg};
  endfunction

  logic cs_s;
  logic sclk_s;
  logic sclk_low;
  logic data_s;
  logic sclk_d1_q;
  logic sclk_rise;
  logic cs_idle;
  logic [2:0] bit_cnt_q;
  logic [7:0] shift_q;
  logic [7:0] shift_d;
  logic [7:0] first_q;
  logic       byte_done;
  logic [7:0] byte_val;
  osd_framer_pkg::frame_state_e state_q;
  logic       bank_q;
  logic [5:0] attr_q;
  logic       is_write_cmd;
  logic       do_store;
  logic [1:0] view;

  // Synchronise link pins
  osd_link_sync u_sync_cs (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .pin_in   (~cs_b),
    .pin_sync (cs_idle)
  );
  osd_link_sync u_sync_clk (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .pin_in   (~sclk),
    .pin_sync (sclk_low)
  );
  osd_link_sync u_sync_dat (
    .clk_sys  (clk_sys),
    .rst_b    (rst_b),
    .pin_in   (sdata),
    .pin_sync (data_s)
  );
  assign cs_s = ~cs_idle;
  // Clock synchronised inverted so its reset level matches the idle-high pin
  assign sclk_s = ~sclk_low;

  // Serial clock edge finder, idle high so no false edge after reset
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      sclk_d1_q <= 1'b1;
    end else begin
      sclk_d1_q <= sclk_s;
    end
  end
  assign sclk_rise = sclk_s & ~sclk_d1_q & ~cs_s;

  // Shift direction selection
  always_comb begin
    if (lsb_first) begin
      shift_d = {data_s, shift_q[7:1]};
    end else begin
      shift_d = {shift_q[6:0], data_s};
    end
  end
  assign byte_done = sclk_rise && (bit_cnt_q == 3'h0);
  assign byte_val  = shift_d;

  // Bit counter and shifter, cleared while deselected
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bit_cnt_q <= `BIT_CNT_RESET;
      shift_q   <= 8'h00;
    end else if (cs_s) begin
      bit_cnt_q <= `BIT_CNT_RESET;
      shift_q   <= 8'h00;
    end else if (sclk_rise) begin
      bit_cnt_q <= bit_cnt_q - 3'h1;
      shift_q   <= shift_d;
    end
  end

  // First byte marks a character write command
  assign is_write_cmd = (first_q[`WRITE_TAG_MSB:`WRITE_TAG_LSB] == `WRITE_TAG);

  // Framing state
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= osd_framer_pkg::ST_FIRST;
      first_q <= 8'h00;
    end else if (cs_s) begin
      state_q <= osd_framer_pkg::ST_FIRST;
    end else if (byte_done) begin
      unique case (state_q)
        osd_framer_pkg::ST_FIRST: begin
          first_q <= byte_val;
          state_q <= osd_framer_pkg::ST_SECOND;
        end
        osd_framer_pkg::ST_SECOND: begin
          if (is_write_cmd && byte_val != `END_CODE) begin
            state_q <= osd_framer_pkg::ST_RUN;
          end else begin
            state_q <= osd_framer_pkg::ST_FIRST;
          end
        end
        osd_framer_pkg::ST_RUN: begin
          if (byte_val == `END_CODE) begin
            state_q <= osd_framer_pkg::ST_FIRST;
          end
        end
        default: state_q <= osd_framer_pkg::ST_FIRST;
      endcase
    end
  end

  // Bank and attributes latched from the first byte only
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      bank_q <= 1'b0;
      attr_q <= 6'h00;
    end else if (byte_done && state_q == osd_framer_pkg::ST_FIRST) begin
      if (lsb_first) begin
        attr_q <= byte_val[5:0];
      end else begin
        attr_q <= {byte_val[2:0], byte_val[5:3]};
      end
      bank_q <= lsb_first ? byte_val[7] : byte_val[0];
    end
  end

  // A character byte that is stored
  assign do_store = byte_done && is_write_cmd && byte_val != `END_CODE
                    && state_q != osd_framer_pkg::ST_FIRST
                    && internal_dot_oscillator;

  // Decoded command output
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cmd_word_q     <= 16'h0000;
      cmd_valid_q    <= 1'b0;
      cmd_two_byte_q <= 1'b0;
    end else begin
      cmd_valid_q <= 1'b0;
      if (byte_done && state_q == osd_framer_pkg::ST_SECOND) begin
        cmd_word_q     <= {first_q, byte_val};
        cmd_valid_q    <= 1'b1;
        cmd_two_byte_q <= 1'b1;
      end
    end
  end

  // Video RAM address, increments and wraps
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      vram_row_q <= `ROW_RESET;
      vram_col_q <= `COL_RESET;
    end else if (vram_we_q) begin
      if (vram_col_q == `LAST_COLUMN) begin
        vram_col_q <= `COL_RESET;
        vram_row_q <= (vram_row_q == `LAST_ROW) ? `ROW_RESET : vram_row_q + 4'h1;
      end else begin
        vram_col_q <= vram_col_q + 5'h01;
      end
    end
  end

  // Video RAM write strobe and data
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      vram_we_q   <= 1'b0;
      vram_char_q <= 9'h000;
      vram_attr_q <= 6'h00;
    end else begin
      vram_we_q <= do_store;
      if (do_store) begin
        vram_char_q <= {bank_q, byte_val};
        vram_attr_q <= attr_q;
      end
    end
  end

  assign view = cell_view(byte_val, bg_enable);

  // Cell classification of the last stored code
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      cell_pass_picture_q <= 1'b1;
      cell_show_bg_q      <= 1'b0;
    end else if (do_store) begin
      cell_pass_picture_q <= view[1];
      cell_show_bg_q      <= view[0];
    end
  end

  // Run status
  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      run_active_q <= 1'b0;
    end else begin
      run_active_q <= (state_q == osd_framer_pkg::ST_RUN) && !cs_s;
    end
  end
endmodule

// ### sim/osd_host_model.sv
// Host side driver of the serial command link
`timescale 1ns/100ps
module osd_host_model (
  // Link pins
  output logic cs_b,
  output logic sclk,
  output logic sdata
);
  // Idle link, clock standing high
  initial begin
    cs_b = 1'b1;
    sclk = 1'b1;
    sdata = 1'b0;
  end
  // Shift n bits, data set while clock low
  task automatic send(input logic [7:0] b, input logic lsb, input int n);
    for (int i = 0; i < n; i++) begin
      sclk = 1'b0;
      sdata = lsb ? b[i] : b[7-i];
      #24 sclk = 1'b1;
      #24;
    end
    #48 sdata = ~sdata;
  endtask
  // Select level, held low across both bytes by callers
  task automatic sel(input logic v);
    cs_b = v;
    #300 sdata = ~sdata;
  endtask
endmodule

// ### sim/osd_serial_command_framer_monitor.sv
// Port checker of the serial command framer
`timescale 1ns/100ps
`include "osd_framer_defs.svh"
module osd_serial_command_framer_monitor (
  // Clock, reset and inputs
  input logic       clk_sys,
  input logic       rst_b,
  input logic       cs_b,
  input logic       internal_dot_oscillator,
  input logic       bg_enable,
  // Design outputs
  input logic       vram_we_q,
  input logic [8:0] vram_char_q,
  input logic [3:0] vram_row_q,
  input logic [4:0] vram_col_q,
  input logic       cell_pass_picture_q,
  input logic       cell_show_bg_q,
  input logic       run_active_q
);
  // One domain for all checks
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rst_b);
  // Stores, codes, addresses, run end on deselect and cell view
  chk_end_not_stored: assert property (vram_we_q |-> vram_char_q[7:0] != `END_CODE)
    else $error("end code stored");
  chk_osc_gates_store: assert property (vram_we_q |-> $past(internal_dot_oscillator))
    else $error("store without oscillator");
  chk_cs_ends_run: assert property (cs_b [*5] |-> !run_active_q)
    else $error("run kept after deselect");
  chk_col_step: assert property ((vram_we_q && vram_col_q != `LAST_COLUMN) |=>
    vram_col_q == $past(vram_col_q) + 5'h01 && $stable(vram_row_q))
    else $error("column step wrong");
  chk_row_step: assert property ((vram_we_q && vram_col_q == `LAST_COLUMN
    && vram_row_q != `LAST_ROW) |=> vram_col_q == `COL_RESET
    && vram_row_q == $past(vram_row_q) + 4'h1)
    else $error("row step wrong");
  chk_wrap_home: assert property ((vram_we_q && vram_col_q == `LAST_COLUMN
    && vram_row_q == `LAST_ROW) |=> vram_col_q == `COL_RESET && vram_row_q == `ROW_RESET)
    else $error("screen wrap wrong");
  chk_off_cell_pass: assert property ((vram_we_q && vram_char_q[7:0] == `DISPLAY_OFF)
    |-> ##[0:1] (cell_pass_picture_q && !cell_show_bg_q))
    else $error("display off cell shows background");
  chk_blank_cell_bg: assert property ((vram_we_q && vram_char_q[7:0] != `DISPLAY_OFF)
    |-> ##[0:1] (cell_show_bg_q == bg_enable && cell_pass_picture_q == !bg_enable))
    else $error("blank cell background wrong");
endmodule
bind osd_serial_command_framer osd_serial_command_framer_monitor mon (
  .clk_sys(clk_sys), .rst_b(rst_b), .cs_b(cs_b), .bg_enable(bg_enable),
  .internal_dot_oscillator(internal_dot_oscillator), .vram_we_q(vram_we_q),
  .vram_char_q(vram_char_q), .vram_row_q(vram_row_q), .vram_col_q(vram_col_q),
  .cell_pass_picture_q(cell_pass_picture_q), .cell_show_bg_q(cell_show_bg_q),
  .run_active_q(run_active_q)
);

// ### sim/osd_serial_command_framer_tb.sv
// Self-checking bench of the serial command framer
`timescale 1ns/100ps
`include "osd_framer_defs.svh"
module osd_serial_command_framer_tb;
  logic        clk_sys = 1'b0;
  logic        rst_b = 1'b0;
  logic        lsb = 1'b0;
  logic        osc = 1'b1;
  logic        bg = 1'b0;
  logic        cs_b, sclk, sdata, we, cv, two, run, pp, sb, ebank;
  int          ncv = 0;
  logic [15:0] word;
  logic [8:0]  chr;
  logic [3:0]  row;
  logic [4:0]  col;
  logic [5:0]  attr, eattr;
  logic [7:0]  b1, b2, ecode;
  logic [3:0]  er = 4'h0;
  logic [4:0]  ec = 5'h00;
  int          err_total = 0;
  int          num_checks = 0;
  int          seed = 32'hf8ea;
  int          nwr = 0;
  always #2 clk_sys = ~clk_sys;
  osd_host_model host (.cs_b(cs_b), .sclk(sclk), .sdata(sdata));
  osd_serial_command_framer dut (.clk_sys(clk_sys), .rst_b(rst_b), .cs_b(cs_b),
    .sclk(sclk), .sdata(sdata), .lsb_first(lsb), .internal_dot_oscillator(osc),
    .bg_enable(bg), .cmd_word_q(word), .cmd_valid_q(cv), .cmd_two_byte_q(two),
    .vram_we_q(we), .vram_char_q(chr), .vram_row_q(row), .vram_col_q(col),
    .vram_attr_q(attr), .cell_pass_picture_q(pp), .cell_show_bg_q(sb),
    .run_active_q(run));
  // Compare and count
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // Expected attributes and bank from the first byte
  function automatic logic [5:0] exp_attr(input logic [7:0] f, input logic l);
    exp_attr = l ? f[5:0] : {f[2:0], f[5:3]};
  endfunction
  function automatic logic exp_bank(input logic [7:0] f, input logic l);
    exp_bank = l ? f[7] : f[0];
  endfunction
  // Expected pass picture and show background of a stored code
  function automatic logic [1:0] exp_cell(input logic [7:0] c, input logic g);
    if (c == `DISPLAY_OFF) exp_cell = 2'b10;
    else exp_cell = {~g, g};
  endfunction
  // Counts and verdict
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Each store against expected cell and address, sampled mid-cycle
  always @(negedge clk_sys) begin
    if (cv === 1'b1) ncv++;
    if (we === 1'b1) begin
      nwr++;
      check(chr, {ebank, ecode});
      check(attr, eattr);
      check({pp, sb}, exp_cell(ecode, bg));
      check({row, col}, {er, ec});
      ec = (ec == `LAST_COLUMN) ? `COL_RESET : ec + 5'h01;
      if (ec == `COL_RESET) er = (er == `LAST_ROW) ? `ROW_RESET : er + 4'h1;
    end
  end
  // Plain two-byte command
  task automatic cmd();
    int v;
    v = ncv;
    b1 = {1'b0, 7'($random(seed))};
    b2 = 8'($random(seed));
    host.send(b1, lsb, 8);
    host.send(b2, lsb, 8);
    check(word, {b1, b2});
    check(two, 1'b1);
    check(16'(ncv), 16'(v + 1));
  endtask
  // Write run of n codes, ended by end code or deselect
  task automatic burst(input int n, input logic ff);
    int w;
    w = nwr + (osc ? n : 0);
    b1 = {2'b11, 6'($random(seed))};
    eattr = exp_attr(b1, lsb);
    ebank = exp_bank(b1, lsb);
    host.send(b1, lsb, 8);
    for (int i = 0; i < n; i++) begin
      ecode = (i == 1) ? `DISPLAY_OFF : 8'($random(seed));
      if (ecode == `END_CODE) ecode = `DISPLAY_OFF;
      host.send(ecode, lsb, 8);
    end
    if (ff) host.send(`END_CODE, lsb, 8);
    else host.sel(1'b1);
    check(run, 1'b0);
    check(16'(nwr), 16'(w));
  endtask
  // Reset, then mixed frames in both bit orders
  initial begin
    repeat (2) @(posedge clk_sys);
    rst_b <= 1'b1;
    repeat (4) @(posedge clk_sys);
    check({we, cv, two, run, pp}, 5'h01);
    for (int k = 0; k < 40; k++) begin
      @(posedge clk_sys);
      lsb <= k[0];
      bg <= k[1];
      osc <= (k % 9 != 4);
      @(posedge clk_sys);
      #1;
      host.sel(1'b0);
      if (k % 4 == 3) begin
        host.send(8'hc5, lsb, k % 7 + 1);
        host.sel(1'b1);
        host.sel(1'b0);
      end
      cmd();
      burst(k % 12 + 6, k[2]);
      if (k[2]) cmd();
      host.sel(1'b1);
    end
    print_verdict();
  end
endmodule
